//--- pms_pkg.sv
// Constants, states and carriers for the power mode sequencer
package pms_pkg;

    // Register offsets and bus widths
    localparam int          ADDR_W     = 8;
    localparam int          DATA_W     = 16;
    localparam logic [7:0]  OFS_MODE   = 8'h00;
    localparam logic [7:0]  OFS_FLAGS  = 8'h04;
    localparam logic [7:0]  OFS_STATUS = 8'h08;
    localparam logic [7:0]  OFS_FUSE   = 8'h0c;

    // Mode command codes
    localparam logic [1:0]  MODE_STANDBY = 2'h0;
    localparam logic [1:0]  MODE_NORMAL  = 2'h1;
    localparam logic [1:0]  MODE_RXONLY  = 2'h2;
    localparam logic [1:0]  MODE_SLEEP   = 2'h3;

    // Flag bit positions
    localparam int          F_SUP_UV  = 0;
    localparam int          F_SUP_OK  = 1;
    localparam int          F_BUCK_UV = 2;
    localparam int          F_BUCK_OK = 3;
    localparam int          F_REG2_UV = 4;
    localparam int          F_REG2_OK = 5;
    localparam int          F_REG3_UV = 6;
    localparam int          F_REG3_OK = 7;
    localparam int          F_WARN    = 8;
    localparam int          F_RECOVER = 9;
    localparam int          F_READY   = 10;
    localparam int          NFLAGS    = 11;
    localparam logic [10:0] FLAGS_RST = 11'h000;

    // Timing: least reset delay rounds up to whole cycles
    localparam int          CLK_PERIOD_NS = 25;
    localparam int          TRES_MIN_US   = 4000;
    localparam int          RES_CYCLES    = (TRES_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          WD_WIN_CYCLES = 4000;
    localparam int          LOAD_CYCLES   = 4;
    localparam int          CNT_W         = 18;
    localparam logic [1:0]  MISS_LIMIT    = 2'h3;

    // Fuse select width and power-up default (2.5V code)
    localparam int          VSEL_W       = 4;
    localparam logic [3:0]  VSEL_DEFAULT = 4'h0;

    typedef enum logic [3:0] {
        ST_BUCK, ST_REG1, ST_RST1, ST_FUSE_POR, ST_FUSE_LOAD, ST_PREREG,
        ST_RES_WAIT, ST_SUWD, ST_RECOV, ST_STANDBY, ST_NORMAL, ST_RXONLY, ST_SLEEP
    } pms_state_e;

    // Analog comparator and host levels, all asynchronous to clk
    typedef struct packed {
        logic buck_power_good;
        logic reg1_ok;
        logic reg1_uv;
        logic reg2_ok;
        logic reg3_ok;
        logic supply_uv;
        logic supply_ok;
        logic supply_below_reset;
        logic temp_warn;
        logic temp_shut;
        logic temp_cool;
        logic wd_trigger;
        logic wake_req;
    } pms_sense_s;

    // Enables and strobes toward the analog blocks
    typedef struct packed {
        logic buck_en;
        logic reg1_en;
        logic reg2_en;
        logic reg3_en;
        logic reg1_reset;
        logic fuse_por_n;
        logic fuse_latch_load;
        logic latch_to_prereg_load;
        logic can_tx_en;
        logic can_rx_en;
        logic lp_rx_en;
    } pms_ctrl_s;

endpackage : pms_pkg

//--- pms_sequencer.sv
// Power mode sequencer: start-up, watchdog, modes, flags and register port
//
// Chosen here: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
module pms_sequencer #(
    parameter logic [17:0] RES_CYCLES    = 18'(pms_pkg::RES_CYCLES),
    parameter logic [17:0] WD_WIN_CYCLES = 18'(pms_pkg::WD_WIN_CYCLES),
    parameter logic [17:0] LOAD_CYCLES   = 18'(pms_pkg::LOAD_CYCLES)
) (
    input  wire logic                 clk,
    input  wire logic                 arst_n,
    input  wire pms_pkg::pms_sense_s  sense,
    input  wire logic [3:0]           fuse_data,
    input  wire logic [7:0]           addr,
    input  wire logic [15:0]          wdata,
    input  wire logic                 wr,
    input  wire logic                 rd,
    output logic [15:0]               rdata,
    output pms_pkg::pms_ctrl_s        ctrl,
    output logic [3:0]                reg1_vsel,
    output logic                      host_reset_n,
    output logic                      host_irq_n
);

    logic [1:0]           rst_sync;
    logic                 rst_n;
    pms_pkg::pms_sense_s  s_meta, s, s_prev;
    pms_pkg::pms_state_e  state, next_state;
    logic [17:0]          cnt, next_cnt;
    logic [1:0]           miss, next_miss;
    logic                 wd_rst, next_wd_rst;
    logic                 recov, next_recov;
    logic                 tx_block, next_tx_block;
    logic                 can_block, next_can_block;
    logic                 lp_block, next_lp_block;
    logic                 ready_pend, next_ready_pend;
    logic [10:0]          flags, next_flags, flag_set, flag_clr;
    logic [3:0]           fuse_latch, next_fuse_latch;
    logic [3:0]           prereg, next_prereg;
    logic                 prereg_ok, next_prereg_ok;
    pms_pkg::pms_ctrl_s   next_ctrl;
    logic                 next_host_reset_n;
    logic [15:0]          next_rdata;
    logic                 in_ops;

    function automatic logic rise(input logic now, input logic was);
        return now & ~was;
    endfunction : rise

    // Reset release through two flip-flops
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // Two-stage synchroniser plus a previous copy for edge detection
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_meta <= '0;
            s      <= '0;
            s_prev <= '0;
        end else begin
            s_meta <= sense;
            s      <= s_meta;
            s_prev <= s;
        end
    end

    assign in_ops = (state == pms_pkg::ST_STANDBY) || (state == pms_pkg::ST_NORMAL) ||
                    (state == pms_pkg::ST_RXONLY);

    // Event flags: hardware set wins over a software clear
    always_comb begin
        flag_set = '0;
        flag_clr = '0;
        if (wr && addr == pms_pkg::OFS_FLAGS) begin
            flag_clr = wdata[10:0];
        end
        flag_clr[pms_pkg::F_WARN] = 1'b0;
        flag_set[pms_pkg::F_SUP_UV] = rise(s.supply_uv, s_prev.supply_uv);
        flag_set[pms_pkg::F_SUP_OK] = rise(s.supply_ok, s_prev.supply_ok);
        flag_set[pms_pkg::F_BUCK_UV] = rise(s_prev.buck_power_good, s.buck_power_good);
        flag_set[pms_pkg::F_BUCK_OK] = rise(s.buck_power_good, s_prev.buck_power_good);
        flag_set[pms_pkg::F_REG2_UV] = ctrl.reg2_en & rise(s_prev.reg2_ok, s.reg2_ok);
        flag_set[pms_pkg::F_REG2_OK] = ctrl.reg2_en & rise(s.reg2_ok, s_prev.reg2_ok);
        flag_set[pms_pkg::F_REG3_UV] = ctrl.reg3_en & rise(s_prev.reg3_ok, s.reg3_ok);
        flag_set[pms_pkg::F_REG3_OK] = ctrl.reg3_en & rise(s.reg3_ok, s_prev.reg3_ok);
        flag_set[pms_pkg::F_WARN] = (state == pms_pkg::ST_NORMAL) &
                                    rise(s.temp_warn, s_prev.temp_warn);
        if (flags[pms_pkg::F_WARN] && s.temp_cool) begin
            flag_clr[pms_pkg::F_WARN]    = 1'b1;
            flag_set[pms_pkg::F_RECOVER] = 1'b1;
        end
        // both regulators ready after normal command from standby
        flag_set[pms_pkg::F_READY] = ready_pend & s.reg2_ok & s.reg3_ok;
        next_flags = (flags & ~flag_clr) | flag_set;
    end

    // Sequencing and mode control
    always_comb begin
        next_state      = state;
        next_cnt        = cnt + 18'h1;
        next_miss       = miss;
        next_wd_rst     = wd_rst;
        next_recov      = recov;
        next_tx_block   = tx_block;
        next_can_block  = can_block;
        next_lp_block   = lp_block;
        next_ready_pend = ready_pend & ~flag_set[pms_pkg::F_READY];
        next_fuse_latch = fuse_latch;
        next_prereg     = prereg;
        next_prereg_ok  = prereg_ok;
        unique case (state)
            // regulator one waits for power good
            pms_pkg::ST_BUCK: if (s.buck_power_good) begin
                next_state = pms_pkg::ST_REG1;
            end
            pms_pkg::ST_REG1: if (s.reg1_ok) begin
                next_state = pms_pkg::ST_RST1;
            end
            pms_pkg::ST_RST1: next_state = pms_pkg::ST_FUSE_POR;
            pms_pkg::ST_FUSE_POR: begin
                next_state = pms_pkg::ST_FUSE_LOAD;
                next_cnt   = '0;
            end
            pms_pkg::ST_FUSE_LOAD: if (cnt >= LOAD_CYCLES - 18'h1) begin
                next_fuse_latch = fuse_data;
                next_state      = pms_pkg::ST_PREREG;
            end
            // fuse setting replaces the default select
            pms_pkg::ST_PREREG: begin
                next_prereg    = fuse_latch;
                next_prereg_ok = 1'b1;
                next_state     = pms_pkg::ST_RES_WAIT;
                next_cnt       = '0;
            end
            pms_pkg::ST_RES_WAIT: if (cnt >= RES_CYCLES - 18'h1) begin
                next_wd_rst = 1'b0;
                next_cnt    = '0;
                next_recov  = 1'b0;
                next_state  = recov ? pms_pkg::ST_STANDBY : pms_pkg::ST_SUWD;
            end
            pms_pkg::ST_SUWD: begin
                if (rise(s.wd_trigger, s_prev.wd_trigger)) begin
                    next_miss  = '0;
                    next_state = pms_pkg::ST_STANDBY;
                end else if (cnt >= WD_WIN_CYCLES - 18'h1 && miss == pms_pkg::MISS_LIMIT - 2'h1) begin
                    next_miss  = '0;
                    next_state = pms_pkg::ST_SLEEP;
                // miss reasserts reset and restarts timeout
                end else if (cnt >= WD_WIN_CYCLES - 18'h1) begin
                    next_miss   = miss + 2'h1;
                    next_wd_rst = 1'b1;
                    next_cnt    = '0;
                    next_state  = pms_pkg::ST_RES_WAIT;
                end
            end
            // wait for regulator one, then timeout to standby
            pms_pkg::ST_RECOV: if (s.reg1_ok) begin
                next_recov = 1'b1;
                next_cnt   = '0;
                next_state = pms_pkg::ST_RES_WAIT;
            end
            pms_pkg::ST_STANDBY, pms_pkg::ST_NORMAL, pms_pkg::ST_RXONLY: begin
                // host mode command from standby onward
                if (wr && addr == pms_pkg::OFS_MODE) begin
                    unique case (wdata[1:0])
                        pms_pkg::MODE_STANDBY: next_state = pms_pkg::ST_STANDBY;
                        pms_pkg::MODE_NORMAL: begin
                            next_state      = pms_pkg::ST_NORMAL;
                            next_ready_pend = (state == pms_pkg::ST_STANDBY);
                        end
                        pms_pkg::MODE_RXONLY: next_state = pms_pkg::ST_RXONLY;
                        pms_pkg::MODE_SLEEP:  next_state = pms_pkg::ST_SLEEP;
                    endcase
                end
                if (flag_set[pms_pkg::F_SUP_UV]) begin
                    next_state = pms_pkg::ST_STANDBY;
                end
                // regulator one undervoltage to the recovery wait
                if (rise(s.reg1_uv, s_prev.reg1_uv)) begin
                    next_state = pms_pkg::ST_RECOV;
                end
            end
            pms_pkg::ST_SLEEP: if (rise(s.wake_req, s_prev.wake_req) && !lp_block) begin
                next_state = pms_pkg::ST_BUCK;
            end
        endcase
        if (flag_set[pms_pkg::F_WARN]) begin
            next_tx_block = 1'b1;
        end
        if (flag_set[pms_pkg::F_RECOVER]) begin
            next_tx_block = 1'b0;
        end
        if (flag_set[pms_pkg::F_BUCK_UV] && (state == pms_pkg::ST_NORMAL ||
                                             state == pms_pkg::ST_RXONLY)) begin
            next_can_block = 1'b1;
        end
        if (flag_set[pms_pkg::F_BUCK_OK]) begin
            next_can_block = 1'b0;
        end
        // shutdown from any mode; receiver back when cool
        if (lp_block && s.temp_cool) begin
            next_lp_block = 1'b0;
        end
        if (rise(s.temp_shut, s_prev.temp_shut)) begin
            next_state    = pms_pkg::ST_SLEEP;
            next_lp_block = 1'b1;
        end
    end

    // Output decode from the next state, registered below
    always_comb begin
        next_ctrl.buck_en              = next_state != pms_pkg::ST_SLEEP;
        // regulator one on except in sleep and the buck power-good wait
        next_ctrl.reg1_en              = next_state != pms_pkg::ST_SLEEP &&
                                         next_state != pms_pkg::ST_BUCK;
        // regulators two, three in normal and receive
        next_ctrl.reg2_en              = next_state == pms_pkg::ST_NORMAL ||
                                         next_state == pms_pkg::ST_RXONLY;
        next_ctrl.reg3_en              = next_ctrl.reg2_en;
        next_ctrl.reg1_reset           = !(next_state inside {pms_pkg::ST_SUWD,
                                           pms_pkg::ST_STANDBY, pms_pkg::ST_NORMAL,
                                           pms_pkg::ST_RXONLY}) && !next_wd_rst;
        next_ctrl.fuse_por_n           = next_state != pms_pkg::ST_FUSE_POR;
        next_ctrl.fuse_latch_load      = next_state == pms_pkg::ST_PREREG;
        next_ctrl.latch_to_prereg_load = next_state == pms_pkg::ST_RES_WAIT &&
                                         state == pms_pkg::ST_PREREG;
        next_ctrl.can_tx_en            = next_state == pms_pkg::ST_NORMAL &&
                                         !next_tx_block && !next_can_block;
        next_ctrl.can_rx_en            = next_ctrl.reg2_en && !next_can_block;
        next_ctrl.lp_rx_en             = (next_state == pms_pkg::ST_STANDBY ||
                                          next_state == pms_pkg::ST_SLEEP) && !next_lp_block;
        // host reset from regulator reset or watchdog
        next_host_reset_n              = !(next_ctrl.reg1_reset || next_wd_rst);
    end

    // Register reads answer one cycle later; unmapped reads zero
    always_comb begin
        next_rdata = '0;
        if (rd) begin
            unique case (addr)
                pms_pkg::OFS_MODE:   next_rdata = {12'h000, state};
                pms_pkg::OFS_FLAGS:  next_rdata = {5'h00, flags};
                pms_pkg::OFS_STATUS: next_rdata = {9'h000, lp_block, can_block, tx_block,
                                                   wd_rst, recov, miss};
                pms_pkg::OFS_FUSE:   next_rdata = {7'h00, prereg_ok, fuse_latch, prereg};
                default:             next_rdata = '0;
            endcase
        end
    end

    // State registers; supply below reset level clears all but the read data
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state        <= pms_pkg::ST_BUCK;
            cnt          <= '0;
            miss         <= '0;
            wd_rst       <= 1'b0;
            recov        <= 1'b0;
            tx_block     <= 1'b0;
            can_block    <= 1'b0;
            lp_block     <= 1'b0;
            ready_pend   <= 1'b0;
            flags        <= pms_pkg::FLAGS_RST;
            fuse_latch   <= '0;
            prereg       <= '0;
            prereg_ok    <= 1'b0;
            ctrl         <= '{buck_en: 1'b1, reg1_reset: 1'b1, fuse_por_n: 1'b1, default: 1'b0};
            host_reset_n <= 1'b0;
            host_irq_n   <= 1'b1;
            rdata        <= '0;
        // supply below reset level resets all of these registers except the read data
        end else if (s.supply_below_reset) begin
            state        <= pms_pkg::ST_BUCK;
            cnt          <= '0;
            miss         <= '0;
            wd_rst       <= 1'b0;
            recov        <= 1'b0;
            tx_block     <= 1'b0;
            can_block    <= 1'b0;
            lp_block     <= 1'b0;
            ready_pend   <= 1'b0;
            flags        <= pms_pkg::FLAGS_RST;
            fuse_latch   <= '0;
            prereg       <= '0;
            prereg_ok    <= 1'b0;
            ctrl         <= '{buck_en: 1'b1, reg1_reset: 1'b1, fuse_por_n: 1'b1, default: 1'b0};
            host_reset_n <= 1'b0;
            host_irq_n   <= 1'b1;
            rdata        <= next_rdata;
        end else begin
            state        <= next_state;
            cnt          <= next_cnt;
            miss         <= next_miss;
            wd_rst       <= next_wd_rst;
            recov        <= next_recov;
            tx_block     <= next_tx_block;
            can_block    <= next_can_block;
            lp_block     <= next_lp_block;
            ready_pend   <= next_ready_pend;
            flags        <= next_flags;
            fuse_latch   <= next_fuse_latch;
            prereg       <= next_prereg;
            prereg_ok    <= next_prereg_ok;
            ctrl         <= next_ctrl;
            host_reset_n <= next_host_reset_n;
            // interrupt held low while a flag is set
            host_irq_n   <= ~(|next_flags);
            rdata        <= next_rdata;
        end
    end

    // default select until the fuse copy is valid
    assign reg1_vsel = prereg_ok ? prereg : pms_pkg::VSEL_DEFAULT;

    // Cycles that the host reset has been held low, saturating
    logic [17:0] low_cnt;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            low_cnt <= '0;
        end else begin
            low_cnt <= host_reset_n ? 18'h0 : (&low_cnt ? low_cnt : low_cnt + 18'h1);
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_reg1_after_pg: assert property ($rose(ctrl.reg1_en) |-> $past(s.buck_power_good))
        else $error("regulator one enabled without power good");
    a_fuse_por_pulse: assert property ($fell(ctrl.fuse_por_n) |=> ctrl.fuse_por_n)
        else $error("fuse power-on pulse not one cycle");
    a_reset_hold_time: assert property ($rose(host_reset_n) |-> low_cnt >= RES_CYCLES)
        else $error("host reset released early");
    a_wd_to_standby: assert property (state == pms_pkg::ST_SUWD && rise(s.wd_trigger, s_prev.wd_trigger)
        && !s.supply_below_reset && !rise(s.temp_shut, s_prev.temp_shut)
        |=> state == pms_pkg::ST_STANDBY)
        else $error("trigger did not reach standby");
    a_wd_miss_reset: assert property (state == pms_pkg::ST_SUWD && next_state == pms_pkg::ST_RES_WAIT
        && !s.supply_below_reset |=> !host_reset_n && cnt == 18'h0)
        else $error("missed trigger did not reassert reset");
    a_miss_sleep: assert property (state == pms_pkg::ST_SUWD && next_state == pms_pkg::ST_SLEEP
        && !rise(s.temp_shut, s_prev.temp_shut) |-> miss == 2'h2)
        else $error("sleep entered on wrong miss count");
    a_normal_regs: assert property (state == pms_pkg::ST_NORMAL |-> ctrl.reg2_en && ctrl.reg3_en)
        else $error("regulators off in normal mode");
    a_sleep_reg1_off: assert property (state == pms_pkg::ST_SLEEP |-> !ctrl.reg1_en && ctrl.reg1_reset)
        else $error("regulator one on in sleep");
    a_warn_tx_off: assert property (state == pms_pkg::ST_NORMAL && flags[pms_pkg::F_WARN]
        |-> !ctrl.can_tx_en && !host_irq_n)
        else $error("transmitter on during warning");
    a_shut_to_sleep: assert property (rise(s.temp_shut, s_prev.temp_shut) && !s.supply_below_reset
        |=> state == pms_pkg::ST_SLEEP && !ctrl.lp_rx_en)
        else $error("shutdown did not enter sleep");
    a_reg1_uv_recov: assert property (in_ops && rise(s.reg1_uv, s_prev.reg1_uv) && !s.supply_below_reset
        && !rise(s.temp_shut, s_prev.temp_shut) |=> state == pms_pkg::ST_RECOV && !host_reset_n)
        else $error("regulator one undervoltage not handled");

    c_reach_normal: cover property (state == pms_pkg::ST_NORMAL && !host_irq_n);
    c_miss_sleep:   cover property (state == pms_pkg::ST_SUWD ##1 state == pms_pkg::ST_SLEEP);
    c_recov_path:   cover property (state == pms_pkg::ST_RECOV ##1 state == pms_pkg::ST_RES_WAIT);
    c_warn_cycle:   cover property ($fell(flags[pms_pkg::F_WARN]));

endmodule : pms_sequencer

//--- pms_host_model.sv
// Host microcontroller model: gives the start-up watchdog trigger
`timescale 1ns/1ps
module pms_host_model (
    input  wire logic clk,
    input  wire logic host_reset_n,
    input  wire logic trig_en,
    output logic      wd_trigger
);
    logic [2:0] cnt;
    always_ff @(posedge clk) begin
        cnt        <= !host_reset_n ? 3'h0 : (cnt == 3'h7) ? cnt : cnt + 3'h1;
        wd_trigger <= trig_en && host_reset_n && cnt >= 3'h3;
    end
endmodule : pms_host_model

//--- tb_power_mode_sequencer.sv
// Self-checking bench for the power mode sequencer
`timescale 1ns/1ps
module tb_power_mode_sequencer;
    logic clk = 0, arst_n = 0, wr = 0, rd = 0, rd_d = 0, wdt, trig_en = 1;
    logic [7:0]  addr = 8'h00;
    logic [15:0] wdata = 16'h0000, rdata, expq[$];
    logic [3:0]  vsel;
    logic host_reset_n, host_irq_n;
    pms_pkg::pms_sense_s sn = '0;
    pms_pkg::pms_ctrl_s  ctrl;
    int err_count = 0, comparisons = 0, cyc = 0, n;
    always #12.5 clk = ~clk;
    pms_sequencer #(.RES_CYCLES(18'h14), .WD_WIN_CYCLES(18'h0a), .LOAD_CYCLES(18'h04)) dut_u (
        .clk(clk), .arst_n(arst_n), .sense(sn | {11'h000, wdt, 1'b0}), .fuse_data(4'ha),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .ctrl(ctrl),
        .reg1_vsel(vsel), .host_reset_n(host_reset_n), .host_irq_n(host_irq_n));
    pms_host_model host_u (.clk(clk), .host_reset_n(host_reset_n), .trig_en(trig_en),
        .wd_trigger(wdt));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic close_out;
        $display("Mismatches %0d, comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : close_out
    task automatic wt(input int k);
        repeat (k) @(posedge clk);
    endtask : wt
    task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        if (w) wr <= 1'b1;
        else begin
            rd <= 1'b1;
            expq.push_back(d);
        end
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
    endtask : bus
    // Read data compared one cycle after the strobe
    always @(posedge clk) rd_d <= rd;
    always @(negedge clk) if (rd_d === 1'b1) chk(rdata, expq.pop_front());
    // Hang guard
    always @(posedge clk) if (++cyc == 5000) begin
        err_count++;
        close_out();
    end
    initial begin
        void'($urandom(32'h1cf434ab));
        wt(20);
        arst_n <= 1'b1;
        wt(5);
        chk(ctrl.reg1_en, 1'b0);
        chk(vsel, pms_pkg::VSEL_DEFAULT);
        sn.buck_power_good <= 1'b1;
        wt(6);
        chk(ctrl.reg1_en, 1'b1);
        sn.reg1_ok <= 1'b1;
        n = 0;
        while (vsel !== 4'ha && n < 40) begin wt(1); n++; end
        chk(vsel, 4'ha);
        chk(host_reset_n, 1'b0);
        n = 0;
        while (host_reset_n !== 1'b1 && n < 60) begin wt(1); n++; end
        chk(16'(n >= 18), 16'h1);
        wt(10);
        bus(1'b0, pms_pkg::OFS_MODE, 16'h0009);
        bus(1'b1, pms_pkg::OFS_MODE, {14'($urandom), pms_pkg::MODE_NORMAL});
        bus(1'b0, pms_pkg::OFS_MODE, 16'h000a);
        wt(1);
        chk({ctrl.reg2_en, ctrl.reg3_en, ctrl.reg1_en}, 3'h7);
        bus(1'b1, pms_pkg::OFS_FLAGS, 16'h07ff);
        wt(1);
        chk(host_irq_n, 1'b1);
        sn.reg2_ok <= 1'b1;
        sn.reg3_ok <= 1'b1;
        wt(6);
        chk(host_irq_n, 1'b0);
        bus(1'b0, pms_pkg::OFS_FLAGS, 16'h04a0);
        chk(ctrl.can_tx_en, 1'b1);
        sn.temp_warn <= 1'b1;
        wt(6);
        chk(ctrl.can_tx_en, 1'b0);
        bus(1'b0, pms_pkg::OFS_MODE, 16'h000a);
        sn.temp_cool <= 1'b1;
        wt(6);
        chk(ctrl.can_tx_en, 1'b1);
        sn.temp_cool <= 1'b0;
        sn.temp_shut <= 1'b1;
        wt(6);
        chk({ctrl.reg1_en, ctrl.lp_rx_en}, 2'h0);
        bus(1'b0, pms_pkg::OFS_MODE, 16'h000c);
        wt(4);
        close_out();
    end
endmodule : tb_power_mode_sequencer
